/* File: src/slb_baud_gen.v */
// baud generator: 13-bit divisor, x16 sample tick and bit tick
// assumes divisor is the committed value
`timescale 1ns/1ns
`default_nettype none

`include "slb_regs.vh"

module slb_baud_gen
(
   input  wire        ref_clk,
   input  wire        srst,
   input  wire        run,
   input  wire [12:0] divisor,
   output reg         rt_tick_q,
   output reg         bit_tick_q
);

   reg [12:0] div_cnt_q;
   reg [3:0]  rt_cnt_q;

   always @(posedge ref_clk)
   begin
      if (srst || !run || divisor == 13'h0000) // (R10)
      begin
         div_cnt_q  <= 13'h0000;
         rt_cnt_q   <= 4'h0;
         rt_tick_q  <= 1'b0;
         bit_tick_q <= 1'b0;
      end
      else
      begin
         // one rt tick per divisor clocks, one bit per 16 rt ticks (R8)
         rt_tick_q  <= 1'b0;
         bit_tick_q <= 1'b0;
         if (div_cnt_q >= divisor - 13'h0001)
         begin
            div_cnt_q <= 13'h0000;
            rt_tick_q <= 1'b1;
            rt_cnt_q  <= rt_cnt_q + 4'h1;
            if (rt_cnt_q == `SLB_RT_PER_BIT)
               bit_tick_q <= 1'b1;
         end
         else
            div_cnt_q <= div_cnt_q + 13'h0001;
      end
   end

endmodule // slb_baud_gen

`default_nettype wire

/* File: src/slb_pin_mux.v */
// receiver source and pin drive selection, combinational
// assumes synchronised pin levels
`timescale 1ns/1ns
`default_nettype none

module slb_pin_mux
(
   input  wire loop_select,
   input  wire receiver_source,
   input  wire open_drain_select,
   input  wire tx_enable,
   input  wire rx_enable,
   input  wire tx_pin_direction,
   input  wire tx_serial_out,
   input  wire tx_gpio_out,
   input  wire rx_gpio_out,
   input  wire rx_gpio_dir,
   input  wire tx_pin_sync,
   input  wire rx_pin_sync,
   output reg  rx_serial_in,
   output reg  tx_pin_o,
   output reg  tx_pin_oe,
   output reg  rx_pin_o,
   output reg  rx_pin_oe
);

   reg tx_val;
   reg tx_drv;
   reg rx_val;
   reg rx_drv;

   always @*
   begin
      tx_val = 1'b1;
      tx_drv = 1'b0;
      rx_val = rx_gpio_out;
      rx_drv = rx_gpio_dir;
      rx_serial_in = 1'b1;
      if (!loop_select)
      begin
         rx_serial_in = rx_pin_sync; // (R21)
         tx_val = tx_enable ? tx_serial_out : tx_gpio_out; // (R20)
         tx_drv = tx_enable | tx_pin_direction;
         if (rx_enable)
            rx_drv = 1'b0;
      end
      else if (!receiver_source)
      begin
         rx_serial_in = tx_serial_out; // (R5)
         tx_val = tx_pin_direction ? tx_serial_out : 1'b1; // (R6)
         tx_drv = 1'b1;
      end
      else
      begin
         // pushed line reads back the driver; open drain reads the wire
         if (tx_pin_direction && !open_drain_select)
            rx_serial_in = tx_serial_out; // (R3)
         else
            rx_serial_in = tx_pin_sync; // (R2) (R4)
         tx_val = tx_serial_out; // (R1)
         tx_drv = tx_pin_direction; // (R6)
      end
      // open drain only pulls low; push-pull drives both levels (R7)
      tx_pin_o  = open_drain_select ? 1'b0 : tx_val;
      tx_pin_oe = tx_drv & (~open_drain_select | ~tx_val);
      rx_pin_o  = open_drain_select ? 1'b0 : rx_val;
      rx_pin_oe = rx_drv & (~open_drain_select | ~rx_val);
   end

endmodule // slb_pin_mux

`default_nettype wire

/* File: src/slb_regs.vh */
// register map, fields and reset values of the loop/baud block
// assumes a 32-bit AXI4-Lite slave, byte address = 4 * index
`ifndef SLB_REGS_VH
`define SLB_REGS_VH

// register indices
`define SLB_IDX_BAUD_HI 10'h0c0
`define SLB_IDX_BAUD_LO 10'h0c1
`define SLB_IDX_LINE_CTRL0 10'h0c2
`define SLB_IDX_ENABLE_CTRL 10'h0c3
`define SLB_IDX_STATUS 10'h0c4
`define SLB_IDX_LINE_CTRL1 10'h0ca

// line control fields
`define SLB_LC_LOOP 7
`define SLB_LC_OPEN_DRAIN 6
`define SLB_LC_RX_SOURCE 5
`define SLB_LC_NINE_BIT 4
`define SLB_LC_WAKE_KIND 3
`define SLB_LC_IDLE_START 2
`define SLB_LC_PARITY_ON 1
`define SLB_LC_PARITY_ODD 0

// enable / interrupt control fields
`define SLB_EC_TX_EMPTY_IE 7
`define SLB_EC_TX_DONE_IE 6
`define SLB_EC_RX_FULL_IE 5
`define SLB_EC_IDLE_IE 4
`define SLB_EC_TX_EN 3
`define SLB_EC_RX_EN 2
`define SLB_EC_STANDBY 1
`define SLB_EC_SEND_BREAK 0

// baud high byte: test bits over divisor bits 12:8
`define SLB_BH_TEST_MASK 8'he0
`define SLB_BH_DIV_MASK 8'h1f

// reset values
`define SLB_RST_LINE_CTRL 8'h00
`define SLB_RST_ENABLE_CTRL 8'h00
`define SLB_RST_BAUD_HI 8'h00
`define SLB_RST_BAUD_LO 8'h04

// last rt count of a bit
`define SLB_RT_PER_BIT 4'hf

// bus answers
`define SLB_RESP_OKAY 2'b00
`define SLB_RESP_SLVERR 2'b10

`endif

/* File: src/slb_top.v */
// loop/single-wire routing, baud control and enable registers
// assumes AXI4-Lite master and transmitter/receiver on ref_clk
// Function
// (R1) single-wire: rx pin freed, tx pin carries both ways
// (R2) single-wire: direction set drives tx pin, clear makes it input
// (R3) loop plus rx source: receiver reads tx pin
// (R4) open drain single-wire receives with direction set
// (R5) loop alone feeds transmitter into receiver
// (R6) loop: direction set drives pin, clear idles or floats
// (R7) open drain select on both pins when outputs
// (R8) rate is clock over 16 times divisor
// (R9) divisor commits on low byte write
// (R10) baud stopped before first enable or at zero divisor
// (R11) test bits writable in special mode only
// (R12) eight or nine data bits
// (R13) standby exit on address mark or idle
// (R14) idle count after stop or start bit
// (R15) parity in top data bit when on
// (R16) odd or even parity
// (R17) tx empty request gated by its enable
// (R18) tx done request gated by its enable
// (R19) rx full and overrun gated by rx full enable
// (R20) enables run transmitter and receiver
// (R21) no loop: rx pin feeds receiver, tx pin driven; the code drives the tx pin only with tx enable or direction set
`timescale 1ns/1ns
`default_nettype none

`include "slb_regs.vh"

module slb_top
(
   input  wire        ref_clk,
   input  wire        srst,
   // axi4-lite slave
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // system
   input  wire        special_mode,
   input  wire        tx_pin_direction,
   input  wire        tx_gpio_out,
   input  wire        rx_gpio_out,
   input  wire        rx_gpio_dir,
   // transmitter / receiver side
   input  wire        tx_serial_out,
   input  wire [8:0]  tx_char,
   input  wire [8:0]  rx_char,
   input  wire        tx_buffer_empty_flag,
   input  wire        tx_done_flag,
   input  wire        rx_full_flag,
   input  wire        overrun_flag,
   input  wire        standby_clear,
   output reg         rx_serial_in_q,
   output reg         tx_enable_q,
   output reg         rx_enable_q,
   output reg         nine_bit_data_q,
   output reg         standby_exit_kind_q,
   output reg         idle_count_start_q,
   output reg         parity_on_q,
   output reg         parity_odd_select_q,
   output reg         idle_irq_en_q,
   output reg         standby_q,
   output reg         send_break_q,
   output reg         tx_parity_bit_q,
   output reg         rx_parity_error_q,
   output reg         rt_tick_q,
   output reg         bit_tick_q,
   output reg         irq_req_q,
   output reg  [3:0]  gpio_tx_pin_q,
   // pins
   input  wire        tx_pin_i,
   output reg         tx_pin_o_q,
   output reg         tx_pin_oe_q,
   input  wire        rx_pin_i,
   output reg         rx_pin_o_q,
   output reg         rx_pin_oe_q
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // parity over the data bits below the parity position (R15) (R16)
   function calc_parity;
      input [8:0] ch;
      input       nine;
      input       odd;
      reg   [7:0] body;
      begin
         body = nine ? ch[7:0] : {1'b0, ch[6:0]};
         calc_parity = (^body) ^ odd;
      end
   endfunction

   function [9:0] word_index;
      input [31:0] addr;
      begin
         word_index = addr[11:2];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   reg tx_pin_meta_q;
   reg tx_pin_sync_q;
   reg rx_pin_meta_q;
   reg rx_pin_sync_q;

   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         tx_pin_meta_q <= 1'b1;
         tx_pin_sync_q <= 1'b1;
         rx_pin_meta_q <= 1'b1;
         rx_pin_sync_q <= 1'b1;
      end
      else
      begin
         tx_pin_meta_q <= tx_pin_i;
         tx_pin_sync_q <= tx_pin_meta_q;
         rx_pin_meta_q <= rx_pin_i;
         rx_pin_sync_q <= rx_pin_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   reg [7:0]  line_ctrl0_q;
   reg [7:0]  line_ctrl1_q;
   reg [7:0]  enable_ctrl_q;
   reg [7:0]  baud_hi_q;
   reg [7:0]  baud_lo_q;
   reg [12:0] divisor_q;
   reg        baud_started_q;

   // write channel state
   reg        aw_held_q;
   reg [9:0]  aw_idx_q;
   reg        w_held_q;
   reg [7:0]  w_byte_q;
   reg        w_lane_q;

   wire       wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
   reg        wr_hit;

   always @*
   begin
      case (aw_idx_q)
         `SLB_IDX_BAUD_HI,
         `SLB_IDX_BAUD_LO,
         `SLB_IDX_LINE_CTRL0,
         `SLB_IDX_ENABLE_CTRL,
         `SLB_IDX_LINE_CTRL1: wr_hit = 1'b1;
         default:             wr_hit = 1'b0;
      endcase
   end

   // address and data taken independently, answer once both are in
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         aw_held_q     <= 1'b0;
         aw_idx_q      <= 10'h000;
         w_held_q      <= 1'b0;
         w_byte_q      <= 8'h00;
         w_lane_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SLB_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_held_q && !s_axi_awready)
         begin
            s_axi_awready <= 1'b1;
            aw_held_q     <= 1'b1;
            aw_idx_q      <= word_index(s_axi_awaddr);
         end
         if (s_axi_wvalid && !w_held_q && !s_axi_wready)
         begin
            s_axi_wready <= 1'b1;
            w_held_q     <= 1'b1;
            w_byte_q     <= s_axi_wdata[7:0];
            w_lane_q     <= s_axi_wstrb[0];
         end
         if (wr_fire)
         begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SLB_RESP_OKAY : `SLB_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   wire wr_en = wr_fire & wr_hit & w_lane_q;

   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         line_ctrl0_q   <= `SLB_RST_LINE_CTRL;
         line_ctrl1_q   <= `SLB_RST_LINE_CTRL;
         enable_ctrl_q  <= `SLB_RST_ENABLE_CTRL;
         baud_hi_q      <= `SLB_RST_BAUD_HI;
         baud_lo_q      <= `SLB_RST_BAUD_LO;
         divisor_q      <= {5'h00, `SLB_RST_BAUD_LO};
         baud_started_q <= 1'b0;
      end
      else
      begin
         if (wr_en && aw_idx_q == `SLB_IDX_LINE_CTRL0)
            line_ctrl0_q <= w_byte_q;
         if (wr_en && aw_idx_q == `SLB_IDX_LINE_CTRL1)
            line_ctrl1_q <= w_byte_q;
         if (wr_en && aw_idx_q == `SLB_IDX_ENABLE_CTRL)
            enable_ctrl_q <= w_byte_q;
         else if (standby_clear)
            enable_ctrl_q[`SLB_EC_STANDBY] <= 1'b0;
         if (wr_en && aw_idx_q == `SLB_IDX_BAUD_HI)
         begin
            // test bits only move in special mode (R11)
            baud_hi_q <= (w_byte_q & `SLB_BH_DIV_MASK) |
                         ((special_mode ? w_byte_q : baud_hi_q)
                          & `SLB_BH_TEST_MASK);
         end
         if (wr_en && aw_idx_q == `SLB_IDX_BAUD_LO)
         begin
            baud_lo_q <= w_byte_q;
            // divisor commits on the low byte only (R9)
            divisor_q <= {baud_hi_q[4:0], w_byte_q};
         end
         if (enable_ctrl_q[`SLB_EC_TX_EN] || enable_ctrl_q[`SLB_EC_RX_EN])
            baud_started_q <= 1'b1; // (R10)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel

   reg [7:0] rd_byte;
   reg       rd_hit;
   reg [9:0] rd_idx;

   always @*
   begin
      rd_idx = word_index(s_axi_araddr);
      rd_hit = 1'b1;
      case (rd_idx)
         `SLB_IDX_BAUD_HI:     rd_byte = baud_hi_q;
         `SLB_IDX_BAUD_LO:     rd_byte = baud_lo_q;
         `SLB_IDX_LINE_CTRL0:  rd_byte = line_ctrl0_q;
         `SLB_IDX_ENABLE_CTRL: rd_byte = enable_ctrl_q;
         `SLB_IDX_LINE_CTRL1:  rd_byte = line_ctrl1_q;
         `SLB_IDX_STATUS:
            rd_byte = {irq_req_q, baud_started_q, rx_parity_error_q,
                       tx_parity_bit_q, tx_buffer_empty_flag,
                       tx_done_flag, rx_full_flag, overrun_flag};
         default:
         begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SLB_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
         begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= rd_hit ? `SLB_RESP_OKAY : `SLB_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // baud generator and pin routing

   wire rt_tick_w;
   wire bit_tick_w;

   slb_baud_gen u_baud
   (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .run        (baud_started_q),
      .divisor    (divisor_q),
      .rt_tick_q  (rt_tick_w),
      .bit_tick_q (bit_tick_w)
   );

   wire rx_in_w;
   wire tx_o_w;
   wire tx_oe_w;
   wire rx_o_w;
   wire rx_oe_w;

   slb_pin_mux u_mux
   (
      .loop_select       (line_ctrl0_q[`SLB_LC_LOOP]),
      .receiver_source   (line_ctrl0_q[`SLB_LC_RX_SOURCE]),
      .open_drain_select (line_ctrl0_q[`SLB_LC_OPEN_DRAIN]),
      .tx_enable         (enable_ctrl_q[`SLB_EC_TX_EN]),
      .rx_enable         (enable_ctrl_q[`SLB_EC_RX_EN]),
      .tx_pin_direction  (tx_pin_direction),
      .tx_serial_out     (tx_serial_out),
      .tx_gpio_out       (tx_gpio_out),
      .rx_gpio_out       (rx_gpio_out),
      .rx_gpio_dir       (rx_gpio_dir),
      .tx_pin_sync       (tx_pin_sync_q),
      .rx_pin_sync       (rx_pin_sync_q),
      .rx_serial_in      (rx_in_w),
      .tx_pin_o          (tx_o_w),
      .tx_pin_oe         (tx_oe_w),
      .rx_pin_o          (rx_o_w),
      .rx_pin_oe         (rx_oe_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // registered outputs

   // every output is a flop, so pins lag the mux by one clock
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         rx_serial_in_q <= 1'b1;
         tx_pin_o_q <= 1'b1;
         tx_pin_oe_q <= 1'b0;
         rx_pin_o_q <= 1'b1;
         rx_pin_oe_q <= 1'b0;
         tx_enable_q <= 1'b0;
         rx_enable_q <= 1'b0;
         nine_bit_data_q <= 1'b0;
         standby_exit_kind_q <= 1'b0;
         idle_count_start_q <= 1'b0;
         parity_on_q <= 1'b0;
         parity_odd_select_q <= 1'b0;
         idle_irq_en_q <= 1'b0;
         standby_q <= 1'b0;
         send_break_q <= 1'b0;
         tx_parity_bit_q <= 1'b0;
         rx_parity_error_q <= 1'b0;
         rt_tick_q <= 1'b0;
         bit_tick_q <= 1'b0;
         irq_req_q <= 1'b0;
         gpio_tx_pin_q <= 4'h0;
      end
      else
      begin
         rx_serial_in_q <= rx_in_w;
         tx_pin_o_q <= tx_o_w;
         tx_pin_oe_q <= tx_oe_w;
         rx_pin_o_q <= rx_o_w;
         rx_pin_oe_q <= rx_oe_w;
         tx_enable_q <= enable_ctrl_q[`SLB_EC_TX_EN]; // (R20)
         rx_enable_q <= enable_ctrl_q[`SLB_EC_RX_EN]; // (R20)
         nine_bit_data_q <= line_ctrl0_q[`SLB_LC_NINE_BIT]; // (R12)
         standby_exit_kind_q <= line_ctrl0_q[`SLB_LC_WAKE_KIND]; // (R13)
         idle_count_start_q <= line_ctrl0_q[`SLB_LC_IDLE_START]; // (R14)
         parity_on_q <= line_ctrl0_q[`SLB_LC_PARITY_ON]; // (R15)
         parity_odd_select_q <= line_ctrl0_q[`SLB_LC_PARITY_ODD]; // (R16)
         idle_irq_en_q <= enable_ctrl_q[`SLB_EC_IDLE_IE];
         standby_q <= enable_ctrl_q[`SLB_EC_STANDBY];
         send_break_q <= enable_ctrl_q[`SLB_EC_SEND_BREAK];
         tx_parity_bit_q <= calc_parity(tx_char,
                               line_ctrl0_q[`SLB_LC_NINE_BIT],
                               line_ctrl0_q[`SLB_LC_PARITY_ODD]);
         // off means never flagged (R15)
         rx_parity_error_q <= line_ctrl0_q[`SLB_LC_PARITY_ON] &
            (calc_parity(rx_char, line_ctrl0_q[`SLB_LC_NINE_BIT],
                         line_ctrl0_q[`SLB_LC_PARITY_ODD]) !=
             (line_ctrl0_q[`SLB_LC_NINE_BIT] ? rx_char[8] : rx_char[7]));
         rt_tick_q <= rt_tick_w;
         bit_tick_q <= bit_tick_w;
         irq_req_q <= // (R17) (R18) (R19)
            (tx_buffer_empty_flag & enable_ctrl_q[`SLB_EC_TX_EMPTY_IE]) |
            (tx_done_flag & enable_ctrl_q[`SLB_EC_TX_DONE_IE]) |
            ((rx_full_flag | overrun_flag) &
             enable_ctrl_q[`SLB_EC_RX_FULL_IE]);
         gpio_tx_pin_q <= {line_ctrl0_q[`SLB_LC_LOOP],
                           line_ctrl0_q[`SLB_LC_RX_SOURCE],
                           line_ctrl0_q[`SLB_LC_OPEN_DRAIN],
                           tx_pin_direction};
      end
   end

endmodule // slb_top

`default_nettype wire

/* File: test/slb_peer.sv */
// peer serial node on the two pulled-up lines
// assumes oe high means the device drives
`timescale 1ns/1ns
`default_nettype none
module slb_peer
(
   input  wire logic tx_pin_o_q,
   input  wire logic tx_pin_oe_q,
   input  wire logic rx_pin_o_q,
   input  wire logic rx_pin_oe_q,
   input  wire logic talk,
   input  wire logic bit_val,
   output logic      tx_line,
   output logic      rx_line
);
   // peer only pulls low; released line reads high
   wire pull = talk ? bit_val : 1'h1;
   assign tx_line = (tx_pin_oe_q ? tx_pin_o_q : 1'h1) & pull;
   assign rx_line = (rx_pin_oe_q ? rx_pin_o_q : 1'h1) & pull;
endmodule // slb_peer
`default_nettype wire

/* File: test/slb_top_properties.sv */
// assertions on slb_top ports: routing, drive, requests, parity
// assumes a bind to slb_top
`timescale 1ns/1ns
`default_nettype none
module slb_top_properties
(
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       tx_serial_out,
   input wire logic [8:0] tx_char,
   input wire logic       rx_gpio_dir,
   input wire logic       rx_gpio_out,
   input wire logic       tx_buffer_empty_flag,
   input wire logic       tx_done_flag,
   input wire logic       rx_full_flag,
   input wire logic       overrun_flag,
   input wire logic       rx_serial_in_q,
   input wire logic       tx_enable_q,
   input wire logic       rx_enable_q,
   input wire logic       nine_bit_data_q,
   input wire logic       parity_on_q,
   input wire logic       parity_odd_select_q,
   input wire logic       tx_parity_bit_q,
   input wire logic       rt_tick_q,
   input wire logic       irq_req_q,
   input wire logic [3:0] gpio_tx_pin_q,
   input wire logic       tx_pin_o_q,
   input wire logic       tx_pin_oe_q,
   input wire logic       rx_pin_o_q,
   input wire logic       rx_pin_oe_q
);
   logic [3:0] g_q;
   logic       seen_q;
   wire  [3:0] g = gpio_tx_pin_q;
   // mode held a cycle, so changes in flight are not judged
   wire        st = g == g_q;
   always @(posedge ref_clk)
   begin
      g_q <= g;
      seen_q <= !srst && (seen_q || tx_enable_q || rx_enable_q);
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
////////////////////////////////////////////////////////////////////////////
a_loop_feed: assert property (st && g[3:2] == 2'h2 |->
   rx_serial_in_q == $past(tx_serial_out)) else $error("loop feed");
a_wire_drive: assert property (st && g == 4'hd && tx_enable_q |->
   rx_serial_in_q == $past(tx_serial_out)) else $error("wire drive");
a_tx_normal: assert property (st && g[3:1] == 3'h0 && tx_enable_q |->
   tx_pin_oe_q && tx_pin_o_q == $past(tx_serial_out)) else $error("tx pin");
a_loop_idle: assert property (st && g == 4'h8 |->
   tx_pin_oe_q && tx_pin_o_q) else $error("loop idle");
a_wire_float: assert property (st && g[3:2] == 2'h3 && !g[0] |->
   !tx_pin_oe_q) else $error("wire float");
a_open_drain: assert property (st && g[1] |-> !(tx_pin_oe_q &&
   tx_pin_o_q) && !(rx_pin_oe_q && rx_pin_o_q)) else $error("open drain");
a_rx_gpio: assert property (st && g[3] |-> rx_pin_oe_q ==
   ($past(rx_gpio_dir) && !(g[1] && $past(rx_gpio_out))))
   else $error("rx gpio");
a_irq_cause: assert property (irq_req_q |-> $past(tx_buffer_empty_flag |
   tx_done_flag | rx_full_flag | overrun_flag)) else $error("irq cause");
a_baud_stopped: assert property (!(seen_q || tx_enable_q || rx_enable_q)
   |-> !rt_tick_q) else $error("baud running");
a_tx_parity: assert property (parity_on_q |-> tx_parity_bit_q ==
   (^($past(tx_char) & (nine_bit_data_q ? 9'h0ff : 9'h07f))
   ^ parity_odd_select_q)) else $error("tx parity");
   cover property (st && g[3:2] == 2'h3 && tx_enable_q);
   cover property (irq_req_q);
   cover property (rt_tick_q);
endmodule // slb_top_properties
bind slb_top slb_top_properties chk (.*);
`default_nettype wire

/* File: test/tb_top.sv */
// bench for slb_top: registers, baud, requests, routing
// assumes slb_regs.vh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "slb_regs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   logic        ref_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, special_mode, tx_pin_direction;
   logic        tx_gpio_out, rx_gpio_out, rx_gpio_dir, tx_serial_out, talk;
   logic        standby_clear, bit_val, tx_buffer_empty_flag, tx_done_flag;
   logic        rx_full_flag, overrun_flag;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
   logic [3:0]  s_axi_wstrb, c, f;
   logic [8:0]  tx_char, rx_char;
   logic [7:0]  d, lc;
   logic [2:0]  e;
   int          errors = 0, total_checks = 0, i, p;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, rx_serial_in_q, tx_enable_q, rx_enable_q;
   wire         nine_bit_data_q, standby_exit_kind_q, idle_count_start_q;
   wire         parity_on_q, parity_odd_select_q, idle_irq_en_q, standby_q;
   wire         send_break_q, tx_parity_bit_q, rx_parity_error_q, rt_tick_q;
   wire         bit_tick_q, irq_req_q, tx_pin_o_q, tx_pin_oe_q, rx_pin_o_q;
   wire         rx_pin_oe_q, tx_line, rx_line;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [3:0]   gpio_tx_pin_q;
   wire [31:0]  s_axi_rdata;
   wire         pk = talk ? bit_val : 1'h1;
   slb_top uut (.*, .tx_pin_i(tx_line), .rx_pin_i(rx_line));
   slb_peer peer (.*);
   initial forever #5 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [9:0] idx, input logic [7:0] v);
      @(posedge ref_clk);
      s_axi_awaddr <= {20'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      fork
         begin do @(posedge ref_clk); while (!s_axi_awready);
            s_axi_awvalid <= 1'h0; end
         begin do @(posedge ref_clk); while (!s_axi_wready);
            s_axi_wvalid <= 1'h0; end
      join
      while (!s_axi_bvalid) @(posedge ref_clk);
      s_axi_bready <= 1'h0;
      `CHK(s_axi_bresp, `SLB_RESP_OKAY)
   endtask
   task automatic rd(input logic [9:0] idx, input logic [7:0] v,
                     input logic [1:0] r = `SLB_RESP_OKAY);
      @(posedge ref_clk);
      s_axi_araddr <= {20'h0, idx, 2'h0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      while (!s_axi_rvalid) @(posedge ref_clk);
      s_axi_rready <= 1'h0;
      `CHK(s_axi_rdata, {24'h0, v})
      `CHK(s_axi_rresp, r)
   endtask
   // tick spacing, capped
   task automatic per(input logic b, input int cap, output int n);
      repeat (3)
      begin
         n = 0;
         do begin @(posedge ref_clk); n++; end
         while ((b ? bit_tick_q : rt_tick_q) !== 1'h1 && n < cap);
      end
   endtask
   function automatic logic tl();
      return ((c[0] | !c[3]) ? tx_serial_out : 1'h1) & pk;
   endfunction
   function automatic logic erx();
      if (!c[3]) return pk;
      if (!c[2] || (c[0] && !c[1])) return tx_serial_out;
      return tl();
   endfunction
   function automatic logic par(logic [8:0] ch);
      return ^(ch & (lc[4] ? 9'h0ff : 9'h07f)) ^ lc[0];
   endfunction
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      final_report();
   end
////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {ref_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
       s_axi_rready, special_mode, tx_pin_direction, tx_gpio_out, talk,
       rx_gpio_out, rx_gpio_dir, tx_serial_out, standby_clear, bit_val,
       tx_buffer_empty_flag, tx_done_flag, rx_full_flag, overrun_flag} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, tx_char, rx_char} = '0;
      {srst, s_axi_wstrb} = 5'h1f;
      void'($urandom(32'hb89ab339));
      repeat (20) @(posedge ref_clk);
      srst <= 1'h0;
      rd(`SLB_IDX_BAUD_HI, 8'h00);
      rd(`SLB_IDX_BAUD_LO, 8'h04);
      rd(`SLB_IDX_LINE_CTRL0, 8'h00);
      rd(`SLB_IDX_LINE_CTRL1, 8'h00);
      rd(`SLB_IDX_ENABLE_CTRL, 8'h00);
      rd(10'h0d0, 8'h00, `SLB_RESP_SLVERR);
      per(0, 60, p);
      `CHK(p, 60)
      wr(`SLB_IDX_BAUD_HI, 8'hff);
      rd(`SLB_IDX_BAUD_HI, 8'h1f);
      special_mode <= 1'h1;
      wr(`SLB_IDX_BAUD_HI, 8'hff);
      rd(`SLB_IDX_BAUD_HI, 8'hff);
      wr(`SLB_IDX_BAUD_HI, 8'h01);
      special_mode <= 1'h0;
      wr(`SLB_IDX_ENABLE_CTRL, 8'h0c);
      @(posedge ref_clk);
      `CHK(tx_enable_q, 1'h1)
      per(0, 9000, p);
      `CHK(p, 4)
      wr(`SLB_IDX_BAUD_LO, 8'h02);
      per(0, 9000, p);
      `CHK(p, 258)
      per(1, 9000, p);
      `CHK(p, 4128)
      wr(`SLB_IDX_BAUD_HI, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         d = i ? 8'($urandom_range(20, 2)) : 8'h01;
         wr(`SLB_IDX_BAUD_LO, d);
         per(0, 9000, p);
         `CHK(p, int'(d))
      end
      wr(`SLB_IDX_BAUD_LO, 8'h00);
      per(0, 60, p);
      `CHK(p, 60)
      wr(`SLB_IDX_BAUD_LO, 8'h03);
      for (i = 0; i < 40; i++)
      begin
         e = 3'($urandom);
         f = 4'($urandom);
         wr(`SLB_IDX_ENABLE_CTRL, {e, 5'h0c});
         {tx_buffer_empty_flag, tx_done_flag, rx_full_flag, overrun_flag} <= f;
         repeat (3) @(posedge ref_clk);
         `CHK(irq_req_q, |(f & {e, e[0]}))
      end
      for (i = 0; i < 48; i++)
      begin
         c = 4'(i);
         lc = {c[3], c[1], c[2], 5'($urandom)};
         wr(`SLB_IDX_LINE_CTRL0, lc);
         rd(`SLB_IDX_LINE_CTRL0, lc);
         tx_pin_direction <= c[0];
         {tx_serial_out, talk, bit_val, rx_gpio_out} <= 4'($urandom);
         rx_gpio_dir <= c[3] & 1'($urandom);
         {tx_char, rx_char} <= 18'($urandom);
         repeat (6) @(posedge ref_clk);
         `CHK(tx_line, tl())
         `CHK(rx_serial_in_q, erx())
         if (c[3]) `CHK(rx_line, (rx_gpio_dir ? rx_gpio_out : 1'h1) & pk)
         if (lc[1]) `CHK(tx_parity_bit_q, par(tx_char))
         `CHK(rx_parity_error_q,
              lc[1] & ((lc[4] ? rx_char[8] : rx_char[7]) != par(rx_char)))
      end
      final_report();
   end
endmodule // tb_top
`default_nettype wire
